// *** src/vat_pkg.sv ***
// Constants, types and field layouts for the virtual address table walker.
// Assumes big-endian bit numbering in the control words: bit 0 is the MSB.
package vat_pkg;

   // -----------------------------------------------------------------
   // Clock and control field positions
   // -----------------------------------------------------------------
   localparam int unsigned CLOCK_PERIOD_NS = 25;
   // Control register 0, bit n sits at vector index 31-n
   localparam int unsigned CR0_PAGE_HI = 31 - 8;
   localparam int unsigned CR0_PAGE_LO = 31 - 9;
   localparam int unsigned CR0_SEG_HI  = 31 - 11;
   localparam int unsigned CR0_SEG_LO  = 31 - 12;
   localparam logic [1:0]  PAGE_2K     = 2'h1;
   localparam logic [1:0]  PAGE_4K     = 2'h2;
   localparam logic [1:0]  SEG_64K     = 2'h0;
   localparam logic [1:0]  SEG_1M      = 2'h2;
   // Control register 1: length bits 0-7, origin bits 8-25
   localparam int unsigned CR1_LEN_HI  = 31;
   localparam int unsigned CR1_LEN_LO  = 24;
   localparam int unsigned CR1_ORG_HI  = 23;
   localparam int unsigned CR1_ORG_LO  = 6;
   // Segment entry: length bits 0-3, origin bits 8-28, invalid bit 31
   localparam int unsigned STE_LEN_HI  = 31;
   localparam int unsigned STE_LEN_LO  = 28;
   localparam int unsigned STE_ORG_HI  = 23;
   localparam int unsigned STE_ORG_LO  = 3;
   localparam int unsigned STE_INV     = 0;
   // Page entry (16 bits): frame bits 0-12, invalid bit 13
   localparam int unsigned PTE_FRM_HI  = 15;
   localparam int unsigned PTE_FRM4_LO = 4;
   localparam int unsigned PTE_FRM2_LO = 3;
   localparam int unsigned PTE_INV     = 2;
   // Reset values and condition codes
   localparam logic [23:0] ADDR_RESET  = 24'h00_0000;
   localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
   localparam logic [1:0]  CC_OK       = 2'h0;
   localparam logic [1:0]  CC_SEG_INV  = 2'h1;
   localparam logic [1:0]  CC_PAGE_INV = 2'h2;
   localparam logic [1:0]  CC_LENGTH   = 2'h3;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_IFETCH    = 3'h0,
      OP_OPERAND   = 3'h1,
      OP_CHANNEL   = 3'h2,
      OP_TRANSLATE = 3'h3,
      OP_REFCLR    = 3'h4,
      OP_FLUSH     = 3'h5
   } op_t;

   typedef enum logic [2:0] {
      FLT_NONE = 3'h0,
      FLT_SPEC = 3'h1,
      FLT_SEG  = 3'h2,
      FLT_PAGE = 3'h3,
      FLT_PRIV = 3'h4
   } fault_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_SEGRD = 4'b0010,
      ST_PGRD  = 4'b0100,
      ST_SPARE = 4'b1000
   } state_t;

   typedef struct packed {
      op_t         op;
      logic [23:0] vaddr;
   } req_t;

   typedef struct packed {
      logic [23:0] addr;
      fault_t      fault;
      logic [1:0]  cc;
   } resp_t;

endpackage

// *** src/virtual_translation_unit.sv ***
// Two-level segment/page table walker for program storage addresses.
// Assumes a processor request port and a real-storage read port that
// answers with memAck one or more cycles after memReq.
`timescale 1ns/10ps

module virtual_translation_unit (
   // Clock, reset, enable
   input  wire logic          clock,
   input  wire logic          rst_b,
   input  wire logic          clkEn,
   // Processor state and control registers
   input  wire logic          translationMode,
   input  wire logic          extendedControl,
   input  wire logic          problemState,
   input  wire logic [31:0]   translationControlReg,
   input  wire logic [31:0]   segTableReg,
   // Request port
   input  wire logic          reqValid,
   input  wire vat_pkg::req_t req,
   output logic               reqReady,
   // Answer port
   output logic               respValid,
   output vat_pkg::resp_t     resp,
   output logic               progInt,
   // Real storage read port
   output logic               memReq,
   output logic [23:0]        memAddr,
   output logic               memHalf,
   input  wire logic          memAck,
   input  wire logic [31:0]   memRdata
);
   import vat_pkg::*;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rstMeta;
   logic rstS;

   // Two-flop release of the asynchronous reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta <= 1'b0;
         rstS    <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstS    <= rstMeta;
      end
   end

   // ----------------------------------------------------------------
   // Address field split
   // ----------------------------------------------------------------
   logic [1:0]  pageSel;
   logic [1:0]  segSel;
   logic        specOk;
   logic        page4k;
   logic        segLarge;
   logic        take;
   logic        xlate;
   logic        privOp;
   req_t        cur;
   logic [7:0]  segIdx;
   logic [8:0]  pageIdx;
   logic [3:0]  pageTop;
   logic [23:0] steAddr;
   logic [23:0] pteAddr;
   logic [31:0] ste;

   // Size selects and their legality
   assign pageSel  = translationControlReg[CR0_PAGE_HI:CR0_PAGE_LO];
   assign segSel   = translationControlReg[CR0_SEG_HI:CR0_SEG_LO];
   assign page4k   = (pageSel == PAGE_4K);
   assign segLarge = (segSel == SEG_1M);
   assign specOk   = ((pageSel == PAGE_2K) || (pageSel == PAGE_4K))
                     && ((segSel == SEG_64K) || (segSel == SEG_1M));
   assign take     = clkEn && reqValid && reqReady;
   assign xlate    = translationMode && extendedControl;
   assign privOp   = (req.op == OP_TRANSLATE) || (req.op == OP_REFCLR) || (req.op == OP_FLUSH);

   // Segment and page index of the latched address
   always_comb begin
      segIdx  = segLarge ? {4'h0, cur.vaddr[23:20]} : cur.vaddr[23:16];
      pageIdx = 9'h000;
      pageTop = 4'h0;
      case ({segLarge, page4k})
         2'b00: begin
            pageIdx = {4'h0, cur.vaddr[15:11]};
            pageTop = pageIdx[4:1];
         end
         2'b01: begin
            pageIdx = {5'h00, cur.vaddr[15:12]};
            pageTop = pageIdx[3:0];
         end
         2'b10: begin
            pageIdx = cur.vaddr[19:11];
            pageTop = pageIdx[8:5];
         end
         default: begin
            pageIdx = {1'b0, cur.vaddr[19:12]};
            pageTop = pageIdx[7:4];
         end
      endcase
   end

   // Table entry addresses
   assign steAddr = {segTableReg[CR1_ORG_HI:CR1_ORG_LO], 6'h00}
                    + {14'h0000, segIdx, 2'h0};
   assign pteAddr = {ste[STE_ORG_HI:STE_ORG_LO], 3'h0}
                    + {14'h0000, pageIdx, 1'b0};

   // ----------------------------------------------------------------
   // Walk sequencer
   // ----------------------------------------------------------------
   state_t      state;
   state_t      next_state;
   req_t        next_cur;
   logic [31:0] next_ste;
   logic        next_reqReady;
   logic        next_respValid;
   resp_t       next_resp;
   logic        next_progInt;
   logic        next_memReq;
   logic [23:0] next_memAddr;
   logic        next_memHalf;
   logic        fin;
   fault_t      finFault;
   logic [1:0]  finCc;
   logic [23:0] finAddr;

   // Next-state and output computation
   always_comb begin
      next_state     = state;
      next_cur       = cur;
      next_ste       = ste;
      next_respValid = 1'b0;
      next_resp      = resp;
      next_progInt   = 1'b0;
      next_memReq    = memReq;
      next_memAddr   = memAddr;
      next_memHalf   = memHalf;
      fin            = 1'b0;
      finFault       = FLT_NONE;
      finCc          = CC_OK;
      finAddr        = ADDR_RESET;
      case (state)
         ST_IDLE: begin
            if (take) begin
               next_cur = req;
               if (privOp && problemState) begin
                  fin      = 1'b1;
                  finFault = FLT_PRIV;
               end else if ((req.op == OP_REFCLR) || (req.op == OP_FLUSH)) begin
                  fin = 1'b1;
               end else if ((req.op == OP_CHANNEL)
                            || ((req.op != OP_TRANSLATE) && !xlate)) begin
                  fin     = 1'b1;
                  finAddr = req.vaddr;
               end else if (!specOk) begin
                  fin      = 1'b1;
                  finFault = FLT_SPEC;
               end else begin
                  next_state = ST_SEGRD;
               end
            end
         end
         ST_SEGRD: begin
            if (segIdx[7:4] > segTableReg[CR1_LEN_HI:CR1_LEN_LO]) begin
               fin      = 1'b1;
               finFault = FLT_SEG;
               finCc    = CC_LENGTH;
            end else if (!memReq) begin
               next_memReq  = 1'b1;
               next_memAddr = steAddr;
               next_memHalf = 1'b0;
            end else if (memAck) begin
               next_memReq = 1'b0;
               next_ste    = memRdata;
               if (memRdata[STE_INV]) begin
                  fin      = 1'b1;
                  finFault = FLT_SEG;
                  finCc    = CC_SEG_INV;
               end else begin
                  next_state = ST_PGRD;
               end
            end
         end
         ST_PGRD: begin
            if (pageTop > ste[STE_LEN_HI:STE_LEN_LO]) begin
               fin      = 1'b1;
               finFault = FLT_PAGE;
               finCc    = CC_LENGTH;
            end else if (!memReq) begin
               next_memReq  = 1'b1;
               next_memAddr = pteAddr;
               next_memHalf = 1'b1;
            end else if (memAck) begin
               next_memReq = 1'b0;
               fin         = 1'b1;
               if (memRdata[PTE_INV]) begin
                  finFault = FLT_PAGE;
                  finCc    = CC_PAGE_INV;
               end else if (page4k) begin
                  finAddr = {memRdata[PTE_FRM_HI:PTE_FRM4_LO], cur.vaddr[11:0]};
               end else begin
                  finAddr = {memRdata[PTE_FRM_HI:PTE_FRM2_LO], cur.vaddr[10:0]};
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (fin) begin
         next_state     = ST_IDLE;
         next_memReq    = 1'b0;
         next_respValid = 1'b1;
         next_resp.addr = finAddr;
         next_resp.fault = finFault;
         // Explicit walks report table faults by condition code only
         if ((next_cur.op == OP_TRANSLATE) && ((finFault == FLT_SEG) || (finFault == FLT_PAGE))) begin
            next_resp.cc = finCc;
         end else begin
            next_resp.cc = CC_OK;
            next_progInt = (finFault != FLT_NONE);
         end
      end
      next_reqReady = (next_state == ST_IDLE);
   end

   // State registers, frozen while the enable is low
   always_ff @(posedge clock or negedge rstS) begin
      if (!rstS) begin
         state     <= ST_IDLE;
         cur       <= '{op: OP_IFETCH, vaddr: ADDR_RESET};
         ste       <= WORD_RESET;
         reqReady  <= 1'b0;
         respValid <= 1'b0;
         resp      <= '{addr: ADDR_RESET, fault: FLT_NONE, cc: CC_OK};
         progInt   <= 1'b0;
         memReq    <= 1'b0;
         memAddr   <= ADDR_RESET;
         memHalf   <= 1'b0;
      end else if (clkEn) begin
         state     <= next_state;
         cur       <= next_cur;
         ste       <= next_ste;
         reqReady  <= next_reqReady;
         respValid <= next_respValid;
         resp      <= next_resp;
         progInt   <= next_progInt;
         memReq    <= next_memReq;
         memAddr   <= next_memAddr;
         memHalf   <= next_memHalf;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Inactive translation passes the address straight through
   property p_pass;
      @(posedge clock) disable iff (!rstS)
      (take && !xlate && ((req.op == OP_IFETCH) || (req.op == OP_OPERAND)))
      |=> (respValid && (resp.addr == $past(req.vaddr)) && !progInt);
   endproperty
   a_pass: assert property (p_pass) else $error("pass-through address wrong");

   // Channel addresses are real even with translation on
   property p_chan;
      @(posedge clock) disable iff (!rstS)
      (take && (req.op == OP_CHANNEL)) |=> (respValid && (resp.addr == $past(req.vaddr)));
   endproperty
   a_chan: assert property (p_chan) else $error("channel address altered");

   // Bad size encoding interrupts before any table read
   property p_spec;
      @(posedge clock) disable iff (!rstS)
      (take && xlate && !specOk && !problemState && (req.op == OP_OPERAND))
      |=> (progInt && (resp.fault == FLT_SPEC) && !memReq);
   endproperty
   a_spec: assert property (p_spec) else $error("specification fault missed");

   // A pending storage read holds its address until answered
   property p_hold;
      @(posedge clock) disable iff (!rstS)
      (memReq && !memAck && clkEn) |=> (memReq && $stable(memAddr) && !respValid);
   endproperty
   a_hold: assert property (p_hold) else $error("storage read dropped");

   // Invalid segment entry ends the walk with a segment fault
   property p_segInv;
      @(posedge clock) disable iff (!rstS)
      (clkEn && (state == ST_SEGRD) && memReq && memAck && memRdata[STE_INV])
      |=> (respValid && (resp.fault == FLT_SEG) && (state == ST_IDLE));
   endproperty
   a_segInv: assert property (p_segInv) else $error("segment fault missed");

   // Invalid page entry ends the walk with a page fault
   property p_pageInv;
      @(posedge clock) disable iff (!rstS)
      (clkEn && (state == ST_PGRD) && memReq && memAck && memRdata[PTE_INV])
      |=> (respValid && (resp.fault == FLT_PAGE));
   endproperty
   a_pageInv: assert property (p_pageInv) else $error("page fault missed");

   // Explicit walks never interrupt on table faults
   property p_explicit;
      @(posedge clock) disable iff (!rstS)
      (respValid && (cur.op == OP_TRANSLATE) && ((resp.fault == FLT_SEG) || (resp.fault == FLT_PAGE)))
      |-> (!progInt && (resp.cc != CC_OK));
   endproperty
   a_explicit: assert property (p_explicit) else $error("explicit fault interrupted");

   // Implicit table faults always interrupt
   property p_implicit;
      @(posedge clock) disable iff (!rstS)
      (respValid && (cur.op != OP_TRANSLATE) && (resp.fault != FLT_NONE)) |-> progInt;
   endproperty
   a_implicit: assert property (p_implicit) else $error("fault not delivered");

   // Segment read goes to origin*64 plus index*4
   property p_steAddr;
      @(posedge clock) disable iff (!rstS)
      (clkEn && (state == ST_SEGRD) && !memReq && !respValid) |=> (!memReq || (memAddr == $past(steAddr)));
   endproperty
   a_steAddr: assert property (p_steAddr) else $error("segment entry address wrong");

   // Privileged ops from problem state are refused
   property p_priv;
      @(posedge clock) disable iff (!rstS)
      (take && privOp && problemState) |=> (progInt && (resp.fault == FLT_PRIV));
   endproperty
   a_priv: assert property (p_priv) else $error("privileged op accepted");

endmodule

// *** verif/real_storage_model.sv ***
// Behavioural real storage answering the walker's table reads.
// Assumes one read at a time; answer comes zero to three enabled cycles late.
`timescale 1ns/10ps
module real_storage_model (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        clkEn,
   // Read port
   input  wire logic        memReq,
   input  wire logic [23:0] memAddr,
   input  wire logic        memHalf,
   output logic             memAck,
   output logic [31:0]      memRdata
);
   logic [7:0] mem [logic [23:0]];
   integer     latSeed = 24;
   integer     waitN   = -1;

   // Unwritten storage reads as a fixed filler byte
   function automatic logic [7:0] rd(input logic [23:0] a);
      return mem.exists(a) ? mem[a] : 8'hA5;
   endfunction

   // Answer after a random wait; released data lines toggle every enabled cycle
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         memAck   <= 1'b0;
         memRdata <= 32'h0000_0000;
         waitN = -1;
      end else if (clkEn) begin
         if (memReq && !memAck) begin
            if (waitN < 0)
               waitN = $random(latSeed) & 3;
            if (waitN == 0) begin
               memAck   <= 1'b1;
               memRdata <= memHalf ? {~memRdata[31:16], rd(memAddr), rd(memAddr + 24'h1)}
                                   : {rd(memAddr), rd(memAddr + 24'h1), rd(memAddr + 24'h2),
                                      rd(memAddr + 24'h3)};
            end
            waitN = waitN - 1;
         end else begin
            memAck   <= 1'b0;
            memRdata <= ~memRdata;
         end
      end
   end
endmodule

// *** verif/virtual_address_table_walker_bench.sv ***
// Self-checking bench for the table walker.
// Assumes the storage model of real_storage_model.sv on the read port.
`timescale 1ns/10ps
module virtual_address_table_walker_bench;
   import vat_pkg::*;
   typedef struct packed {
      resp_t r;
      logic  chkA;
      logic  chkC;
      logic  pi;
   } note_t;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        clkEn = 1'b1;
   logic        translationMode = 1'b0;
   logic        extendedControl = 1'b0;
   logic        problemState = 1'b0;
   logic [31:0] translationControlReg = 32'h0040_0000;
   logic [31:0] segTableReg = 32'h0000_0000;
   logic        reqValid = 1'b0;
   req_t        req = '0;
   logic        reqReady, respValid, progInt, memReq, memHalf, memAck;
   resp_t       resp;
   logic [23:0] memAddr;
   logic [31:0] memRdata;
   note_t       notes[$];
   logic [24:0] mems[$];
   integer      seed = 24;
   int          nMismatch = 0;
   int          nTests = 0;

   virtual_translation_unit DUT (.clock(clock), .rst_b(rst_b), .clkEn(clkEn),
      .translationMode(translationMode), .extendedControl(extendedControl), .problemState(problemState),
      .translationControlReg(translationControlReg), .segTableReg(segTableReg), .reqValid(reqValid),
      .req(req), .reqReady(reqReady), .respValid(respValid), .resp(resp), .progInt(progInt),
      .memReq(memReq), .memAddr(memAddr), .memHalf(memHalf), .memAck(memAck), .memRdata(memRdata));
   real_storage_model STORE (.clock(clock), .rst_b(rst_b), .clkEn(clkEn), .memReq(memReq),
      .memAddr(memAddr), .memHalf(memHalf), .memAck(memAck), .memRdata(memRdata));

   // ----------------------------------------------------------------
   // Clock, random enable, watchdog
   // ----------------------------------------------------------------
   always #(CLOCK_PERIOD_NS / 2.0) clock = ~clock;
   always @(posedge clock) begin
      if (rst_b)
         clkEn <= ($random(seed) & 7) != 0;
   end
   initial begin
      repeat (20000) @(posedge clock);
      nMismatch++;
      printVerdict;
   end

   // ----------------------------------------------------------------
   // Checking tasks
   // ----------------------------------------------------------------
   task automatic printVerdict;
      $display("checks %0d, mismatches %0d", nTests, nMismatch);
      if (nMismatch == 0 && nTests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic bad(input logic [63:0] got, input logic [63:0] exp);
      nMismatch++;
      $display("unexpected value at %0t ns: got %h expected %h", $time, got, exp);
   endtask
   task automatic checkResp(input note_t n);
      nTests++;
      // The answer edge also reopens the request port
      if (resp.fault !== n.r.fault || progInt !== n.pi || (n.chkA && resp.addr !== n.r.addr) ||
          (n.chkC && resp.cc !== n.r.cc) || reqReady !== 1'b1)
         bad(64'({reqReady, resp, progInt}), 64'({1'b1, n.r, n.pi}));
   endtask
   task automatic checkMem(input logic [24:0] e);
      nTests++;
      if ({memAddr, memHalf} !== e)
         bad(64'({memAddr, memHalf}), 64'(e));
   endtask

   // Each answer against the oldest note, each storage read against the oldest expected read
   always @(posedge clock) begin
      if (rst_b && clkEn) begin
         if (respValid === 1'b1) begin
            if (notes.size() == 0)
               bad(64'(resp), 64'h0);
            else
               checkResp(notes.pop_front());
         end
         if (memReq === 1'b1 && memAck === 1'b1) begin
            if (mems.size() == 0)
               bad(64'({memAddr, memHalf}), 64'h0);
            else
               checkMem(mems.pop_front());
         end
      end
   end

   // ----------------------------------------------------------------
   // Driving tasks
   // ----------------------------------------------------------------
   task automatic note(input logic [23:0] a, input fault_t f, input logic [1:0] c, input logic ca,
                       input logic cc, input logic pi);
      notes.push_back('{r: '{addr: a, fault: f, cc: c}, chkA: ca, chkC: cc, pi: pi});
   endtask
   task automatic send(input op_t op, input logic [23:0] v, input bit keep);
      req      <= '{op: op, vaddr: v};
      reqValid <= 1'b1;
      do @(posedge clock); while (!(reqReady === 1'b1 && clkEn === 1'b1));
      if (!keep)
         reqValid <= 1'b0;
   endtask
   task automatic settle;
      for (int i = 0; i < 400 && notes.size() + mems.size() != 0; i++) @(posedge clock);
      if (notes.size() + mems.size() != 0) begin
         nMismatch++;
         printVerdict;
      end
   endtask
   task automatic put(input logic [23:0] a, input logic [31:0] w, input int n);
      for (int i = 0; i < n; i++) STORE.mem[a + 24'(i)] = w[31 - 8 * i -: 8];
   endtask

   // One walk; kind 0 ok, 1 segment invalid, 2 page invalid, 3 page length, 4 segment length
   task automatic walk(input logic pg4k, input logic seg1m, input int kind, input bit expl, input int k);
      logic [23:0] v, steA, ptOrg, pteA, realA;
      logic [12:0] frm;
      logic [7:0]  segIdx, segLen;
      logic [8:0]  pIdx;
      logic [3:0]  pTop, ptLen;
      int          sSh, pSh, pBits;
      fault_t      f;
      sSh = seg1m ? 20 : 16;
      pSh = pg4k ? 12 : 11;
      pBits = sSh - pSh;
      v = 24'($random(seed));
      frm = 13'($random(seed));
      if (kind == 3)
         v[sSh - 1] = 1'b1;
      if (kind == 4)
         v[23] = 1'b1;
      segIdx = 8'(v >> sSh);
      pIdx = 9'(v >> pSh) & 9'((1 << pBits) - 1);
      pTop = 4'(pIdx >> (pBits - 4));
      ptLen = (kind == 3) ? pTop - 4'h1 : 4'hF;
      segLen = (kind == 4) ? 8'h00 : 8'h0F;
      ptOrg = 24'h10_0000 + 24'(k) * 24'h400;
      steA = 24'h00_4000 + 24'(segIdx) * 24'h4;
      pteA = ptOrg + 24'(pIdx) * 24'h2;
      realA = pg4k ? {frm[12:1], v[11:0]} : {frm, v[10:0]};
      put(steA, {ptLen, 4'h0, ptOrg[23:3], 2'b00, kind == 1}, 4);
      put(pteA, {pg4k ? {frm[12:1], 1'b0} : frm, kind == 2, 2'b00, 16'h0}, 2);
      translationControlReg <= {8'h00, pg4k ? PAGE_4K : PAGE_2K, 1'b0, seg1m ? SEG_1M : SEG_64K, 19'h0};
      segTableReg <= {segLen, 18'h0_0100, 6'h0};
      translationMode <= expl ? 1'($random(seed)) : 1'b1;
      extendedControl <= expl ? 1'($random(seed)) : 1'b1;
      problemState <= expl ? 1'b0 : 1'($random(seed));
      f = (kind == 1 || kind == 4) ? FLT_SEG : (kind == 0) ? FLT_NONE : FLT_PAGE;
      if (kind != 4)
         mems.push_back({steA, 1'b0});
      if (kind == 0 || kind == 2)
         mems.push_back({pteA, 1'b1});
      note(realA, f, expl ? 2'(kind > 2 ? 3 : kind) : CC_OK, kind == 0, 1'b1,
           !expl && kind != 0);
      send(expl ? OP_TRANSLATE : (k[0] ? OP_IFETCH : OP_OPERAND), v, 1'b0);
      settle;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [23:0] v;
      logic [3:0]  badCfg [4];
      badCfg = '{4'b0000, 4'b1100, 4'b0101, 4'b0111};
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      // Pass-through back to back; last pair is channel traffic with translation on
      for (int i = 0; i < 4; i++) begin
         translationMode <= i[0];
         extendedControl <= i[1];
         problemState <= 1'($random(seed));
         v = 24'($random(seed));
         note(v, FLT_NONE, CC_OK, 1'b1, 1'b0, 1'b0);
         send(i == 3 ? OP_CHANNEL : OP_IFETCH, v, 1'b1);
         note(~v, FLT_NONE, CC_OK, 1'b1, 1'b0, 1'b0);
         send(i == 3 ? OP_CHANNEL : OP_OPERAND, ~v, 1'b0);
         settle;
      end
      // Every size setting and fault kind, implicit and explicit, except segment length with 1M segments
      for (int c = 0; c < 4; c++)
         for (int kd = 0; kd < 5; kd++)
            for (int e = 0; e < 2; e++)
               if (!(c[1] && kd == 4))
                  walk(c[0], c[1], kd, e[0], c * 10 + kd * 2 + e);
      // Table instructions in problem state, both modes; reference clear and flush only in supervisor state
      for (int i = 0; i < 12; i++) begin
         problemState <= i < 6;
         extendedControl <= i[0];
         note(24'h0, i < 6 ? FLT_PRIV : FLT_NONE, CC_OK, 1'b0, 1'b0, i < 6);
         send(i < 6 ? op_t'(3 + i / 2) : op_t'(4 + (i % 2)), 24'h0, 1'b0);
         settle;
      end
      // Invalid size encodings interrupt for both request kinds
      problemState <= 1'b0;
      translationMode <= 1'b1;
      extendedControl <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         translationControlReg <= {8'h00, badCfg[i / 2][3:2], 1'b0, badCfg[i / 2][1:0], 19'h0};
         note(24'h0, FLT_SPEC, CC_OK, 1'b0, 1'b0, 1'b1);
         send(i[0] ? OP_TRANSLATE : OP_OPERAND, 24'($random(seed)), 1'b0);
         settle;
      end
      printVerdict;
   end
endmodule
